//--- rtl/irqa_regs.vh
/*
 * Register offsets, field positions and reset values of the interrupt
 * pending aggregator. Assumes a 12-bit APB byte address, 32-bit data.
 */
`ifndef IRQA_REGS_VH
`define IRQA_REGS_VH

// Byte offsets, one aligned word each
`define IRQA_OFF_BASIC 12'h200
`define IRQA_OFF_PEND_LO 12'h204
`define IRQA_OFF_PEND_HI 12'h208
`define IRQA_OFF_FAST 12'h20c
`define IRQA_OFF_EN_LO 12'h210
`define IRQA_OFF_EN_HI 12'h214
`define IRQA_OFF_EN_BASIC 12'h218
`define IRQA_OFF_DIS_LO 12'h21c
`define IRQA_OFF_DIS_HI 12'h220
`define IRQA_OFF_DIS_BASIC 12'h224
`define IRQA_OFF_EV_STAT 12'h228
`define IRQA_OFF_EV_MASK 12'h22c
`define IRQA_OFF_ROUTE 12'h230

// Basic pending register layout
`define IRQA_BASIC_SUM_LO 8
`define IRQA_BASIC_SUM_HI 9
`define IRQA_BASIC_MIR_LSB 10
`define IRQA_BASIC_MIR_MSB 20

// Graphics sources copied into the basic register
`define IRQA_MIRROR_LO 32'h000c0680
`define IRQA_MIRROR_HI 32'h43e00000

// Fast interrupt control fields
`define IRQA_FAST_SEL_MSB 6
`define IRQA_FAST_EN_BIT 7
`define IRQA_FAST_LOCAL_BASE 7'h40

// Event status bits
`define IRQA_EV_NORMAL 0
`define IRQA_EV_FAST 1
`define IRQA_EV_BADADDR 2
`define IRQA_EV_W 3

// Reset values
`define IRQA_EN_RST 32'h00000000
`define IRQA_FAST_RST 8'h00
`define IRQA_EV_RST 3'h0

`endif

//--- rtl/irqa_sync.v
/*
 * Two-flop level synchroniser for a bus of independent request lines.
 * Assumes each bit is a slow level; no multi-bit coherence is implied.
 */
`timescale 1ns/10ps
`default_nettype none

module irqa_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // irqa_sync

`default_nettype wire

//--- rtl/irqa_fast_sel.v
/*
 * Fast interrupt selector: picks one source out of the pending vector and
 * gates it with the fast enable. Assumes the vector is already synchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module irqa_fast_sel #(
  parameter NSRC = 72,
  parameter SELW = 7
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Selection
  input wire [NSRC-1:0] src_vec,
  input wire [SELW-1:0] sel,
  input wire fast_en,
  // Output
  output reg fast_out
);

  wire hit;

  // Indices beyond the vector select nothing
  assign hit = (sel < NSRC) ? src_vec[sel] : 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_out <= 1'b0;
    end else begin
      fast_out <= fast_en & hit;
    end
  end

endmodule // irqa_fast_sel

`default_nettype wire

//--- rtl/irqa_top.v
/*
 * Interrupt pending aggregator: collects local and 64 graphics-side level
 * requests, keeps enables, shows pending state, drives normal and fast
 * interrupt lines. Assumes an APB master on pclk; request pins are async.
 */
`timescale 1ns/10ps
`default_nettype none

`include "irqa_regs.vh"

module irqa_top #(
  parameter NGFX = 64
) (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Graphics-side requests
  input wire [NGFX-1:0] gfx_req,
  // Local requests
  input wire timer_req,
  input wire [1:0] mbox_req,
  input wire [3:0] door_req,
  input wire [1:0] halt_req,
  input wire [1:0] err_req,
  // Host processor interrupt lines
  output reg normal_irq,
  output wire fast_irq,
  // Messaging interrupts routed to the graphics side
  output reg [2:0] gfx_msg_irq,
  // Block event interrupt
  output reg status_irq
);

  localparam NLOC = 8;
  localparam NALL = NGFX + NLOC;
  localparam NPIN = NGFX + 11;

  wire [NPIN-1:0] pin_sync;
  wire [NGFX-1:0] gfx_pend;
  wire timer_s;
  wire [1:0] mbox_s;
  wire [3:0] door_s;
  wire [1:0] halt_s;
  wire [1:0] err_s;

  reg [31:0] en_lo_reg;
  reg [31:0] en_hi_reg;
  reg [7:0] en_basic_reg;
  reg [7:0] fast_reg;
  reg route_swap_reg;
  reg [`IRQA_EV_W-1:0] ev_stat_reg;
  reg [`IRQA_EV_W-1:0] ev_mask_reg;
  reg fast_irq_d_reg;
  reg normal_irq_d_reg;

  reg [31:0] en_lo_next;
  reg [31:0] en_hi_next;
  reg [31:0] en_basic_next;
  reg [`IRQA_EV_W-1:0] ev_stat_next;
  reg [`IRQA_EV_W-1:0] ev_set;
  reg [31:0] rdata_next;
  reg hit;

  wire [31:0] pend_lo;
  wire [31:0] pend_hi;
  wire [7:0] local_pend;
  wire [31:0] basic_pend;
  wire [2:0] host_msg;
  wire [2:0] gfx_msg;
  wire [NALL-1:0] pend_all;
  wire [NALL-1:0] en_all;
  wire [NALL-1:0] fast_mask;
  wire [NALL-1:0] normal_vec;
  wire wr_acc;
  wire setup;

  // All request pins cross into pclk before anything looks at them
  irqa_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({err_req, halt_req, door_req, mbox_req, timer_req, gfx_req}),
    .sync_out(pin_sync)
  );

  assign gfx_pend = pin_sync[NGFX-1:0];
  assign timer_s = pin_sync[NGFX];
  assign mbox_s = pin_sync[NGFX+2:NGFX+1];
  assign door_s = pin_sync[NGFX+6:NGFX+3];
  assign halt_s = pin_sync[NGFX+8:NGFX+7];
  assign err_s = pin_sync[NGFX+10:NGFX+9];

  assign pend_lo = gfx_pend[31:0];
  assign pend_hi = gfx_pend[63:32];

  // Mailbox 0 and doorbells 0/1 face the host unless swapped
  assign host_msg = route_swap_reg ? {door_s[3], door_s[2], mbox_s[1]} :
    {door_s[1], door_s[0], mbox_s[0]};
  assign gfx_msg = route_swap_reg ? {door_s[1], door_s[0], mbox_s[0]} :
    {door_s[3], door_s[2], mbox_s[1]};

  // Timer, mailbox, two doorbells, two halts, two access errors
  assign local_pend = {err_s[0], err_s[1], halt_s[1], halt_s[0],
    host_msg[2], host_msg[1], host_msg[0], timer_s};

  // Graphics source shown at basic bit MIR_LSB + k
  function [5:0] irqa_mir_src;
    input [31:0] k;
    begin
      case (k)
        32'h00000000: irqa_mir_src = 6'h07;
        32'h00000001: irqa_mir_src = 6'h09;
        32'h00000002: irqa_mir_src = 6'h0a;
        32'h00000003: irqa_mir_src = 6'h12;
        32'h00000004: irqa_mir_src = 6'h13;
        32'h00000005: irqa_mir_src = 6'h35;
        32'h00000006: irqa_mir_src = 6'h36;
        32'h00000007: irqa_mir_src = 6'h37;
        32'h00000008: irqa_mir_src = 6'h38;
        32'h00000009: irqa_mir_src = 6'h39;
        32'h0000000a: irqa_mir_src = 6'h3e;
        default: irqa_mir_src = 6'h00;
      endcase
    end
  endfunction

  // Summary bits ignore sources already copied into the basic register
  assign basic_pend[7:0] = local_pend;
  assign basic_pend[`IRQA_BASIC_SUM_LO] =
    |(pend_lo & ~`IRQA_MIRROR_LO);
  assign basic_pend[`IRQA_BASIC_SUM_HI] =
    |(pend_hi & ~`IRQA_MIRROR_HI);
  genvar mi;
  generate
    for (mi = 0; mi <= `IRQA_BASIC_MIR_MSB - `IRQA_BASIC_MIR_LSB; mi = mi + 1) begin : g_mirror
      assign basic_pend[`IRQA_BASIC_MIR_LSB + mi] = gfx_pend[irqa_mir_src(mi)];
    end
  endgenerate
  assign basic_pend[31:21] = 11'h000;

  // Flat source vector: graphics 0..63, then local 64..71
  assign pend_all = {local_pend, gfx_pend};
  assign en_all = {en_basic_reg, en_hi_reg, en_lo_reg};

  // Fast source is held off the normal line while fast is enabled
  assign fast_mask = fast_reg[`IRQA_FAST_EN_BIT] ?
    ({{(NALL-1){1'b0}}, 1'b1} << fast_reg[`IRQA_FAST_SEL_MSB:0]) :
    {NALL{1'b0}};
  genvar si;
  generate
    for (si = 0; si < NALL; si = si + 1) begin : g_normal
      assign normal_vec[si] = pend_all[si] & en_all[si] & ~fast_mask[si];
    end
  endgenerate

  irqa_fast_sel #(
    .NSRC(NALL),
    .SELW(7)
  ) u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .src_vec(pend_all),
    .sel(fast_reg[`IRQA_FAST_SEL_MSB:0]),
    .fast_en(fast_reg[`IRQA_FAST_EN_BIT]),
    .fast_out(fast_irq)
  );

  // Zero wait states; errors only for unmapped or misaligned words
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & hit;
  assign pslverr = psel & penable & ~hit;

  // Register write decode, shared by every writable word
  function irqa_wr_to;
    input acc;
    input [11:0] addr;
    input [11:0] off;
    begin
      irqa_wr_to = acc & (addr == off);
    end
  endfunction

  wire wr_en_lo;
  wire wr_en_hi;
  wire wr_en_basic;
  wire wr_dis_lo;
  wire wr_dis_hi;
  wire wr_dis_basic;
  wire wr_fast;
  wire wr_route;
  wire wr_ev_stat;
  wire wr_ev_mask;
  assign wr_en_lo = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_EN_LO);
  assign wr_en_hi = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_EN_HI);
  assign wr_en_basic = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_EN_BASIC);
  assign wr_dis_lo = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_DIS_LO);
  assign wr_dis_hi = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_DIS_HI);
  assign wr_dis_basic = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_DIS_BASIC);
  assign wr_fast = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_FAST);
  assign wr_route = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_ROUTE);
  assign wr_ev_stat = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_EV_STAT);
  assign wr_ev_mask = irqa_wr_to(wr_acc, paddr, `IRQA_OFF_EV_MASK);

  // Set and clear on one write word; a disable beats an enable
  function [31:0] irqa_upd;
    input [31:0] cur;
    input [31:0] wd;
    input set;
    input clr;
    begin
      irqa_upd = cur;
      if (set) begin
        irqa_upd = irqa_upd | wd;
      end
      if (clr) begin
        irqa_upd = irqa_upd & ~wd;
      end
    end
  endfunction

  always @* begin
    hit = 1'b1;
    rdata_next = 32'h00000000;
    case (paddr)
      `IRQA_OFF_BASIC: rdata_next = basic_pend;
      `IRQA_OFF_PEND_LO: rdata_next = pend_lo;
      `IRQA_OFF_PEND_HI: rdata_next = pend_hi;
      `IRQA_OFF_FAST: rdata_next = {24'h000000, fast_reg};
      `IRQA_OFF_EN_LO,
      `IRQA_OFF_DIS_LO: rdata_next = en_lo_reg;
      `IRQA_OFF_EN_HI,
      `IRQA_OFF_DIS_HI: rdata_next = en_hi_reg;
      `IRQA_OFF_EN_BASIC,
      `IRQA_OFF_DIS_BASIC: rdata_next = {24'h000000, en_basic_reg};
      `IRQA_OFF_EV_STAT: rdata_next = {29'h00000000, ev_stat_reg};
      `IRQA_OFF_EV_MASK: rdata_next = {29'h00000000, ev_mask_reg};
      `IRQA_OFF_ROUTE: rdata_next = {31'h00000000, route_swap_reg};
      default: hit = 1'b0;
    endcase
  end

  always @* begin
    en_lo_next = irqa_upd(en_lo_reg, pwdata,
      wr_en_lo,
      wr_dis_lo);
    en_hi_next = irqa_upd(en_hi_reg, pwdata,
      wr_en_hi,
      wr_dis_hi);
    en_basic_next = irqa_upd({24'h000000, en_basic_reg}, pwdata,
      wr_en_basic,
      wr_dis_basic);
  end

  // New events win over a write-one-to-clear in the same cycle
  always @* begin
    ev_set = {`IRQA_EV_W{1'b0}};
    ev_set[`IRQA_EV_NORMAL] = normal_irq & ~normal_irq_d_reg;
    ev_set[`IRQA_EV_FAST] = fast_irq & ~fast_irq_d_reg;
    ev_set[`IRQA_EV_BADADDR] = pslverr;
    ev_stat_next = ev_stat_reg;
    if (wr_ev_stat) begin
      ev_stat_next = ev_stat_reg & ~pwdata[`IRQA_EV_W-1:0];
    end
    ev_stat_next = ev_stat_next | ev_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_lo_reg <= `IRQA_EN_RST;
      en_hi_reg <= `IRQA_EN_RST;
      en_basic_reg <= 8'h00;
      fast_reg <= `IRQA_FAST_RST;
      route_swap_reg <= 1'b0;
      ev_stat_reg <= `IRQA_EV_RST;
      ev_mask_reg <= `IRQA_EV_RST;
      prdata <= 32'h00000000;
    end else begin
      en_lo_reg <= en_lo_next;
      en_hi_reg <= en_hi_next;
      en_basic_reg <= en_basic_next[7:0];
      ev_stat_reg <= ev_stat_next;
      if (wr_fast) begin
        fast_reg <= pwdata[7:0];
      end
      if (wr_route) begin
        route_swap_reg <= pwdata[0];
      end
      if (wr_ev_mask) begin
        ev_mask_reg <= pwdata[`IRQA_EV_W-1:0];
      end
      // Read data is latched in the setup cycle so it is stable in access
      if (setup && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // Plain OR of enabled sources, minus the fast source: software polls to find which ones are live
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      normal_irq <= 1'b0;
      normal_irq_d_reg <= 1'b0;
      fast_irq_d_reg <= 1'b0;
      gfx_msg_irq <= 3'h0;
      status_irq <= 1'b0;
    end else begin
      normal_irq <= |normal_vec;
      normal_irq_d_reg <= normal_irq;
      fast_irq_d_reg <= fast_irq;
      gfx_msg_irq <= gfx_msg;
      status_irq <= |(ev_stat_next & ev_mask_reg);
    end
  end

endmodule // irqa_top

`default_nettype wire

//--- test/irqa_chk.sv
/* Port checker for irqa_top, bound at the foot.
   Follows the routing bit through completed bus writes. */
`timescale 1ns/10ps
`default_nettype none
`include "irqa_regs.vh"
module irqa_chk #(
  parameter NGFX = 64
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Requests
  input wire [NGFX-1:0] gfx_req,
  input wire timer_req,
  input wire [1:0] mbox_req,
  input wire [3:0] door_req,
  input wire [1:0] halt_req,
  input wire [1:0] err_req,
  // Lines
  input wire normal_irq,
  input wire fast_irq,
  input wire [2:0] gfx_msg_irq
);
  wire [NGFX+10:0] req = {gfx_req, timer_req, mbox_req, door_req, halt_req, err_req};
  // Shadow of the routing bit, taken from completed bus writes
  logic route_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= 1'b0;
    end else if (psel && penable && pwrite && paddr == `IRQA_OFF_ROUTE) begin
      route_q <= pwdata[0];
    end
  end
  wire [2:0] host = route_q ? {door_req[3:2], mbox_req[1]} : {door_req[1:0], mbox_req[0]};
  wire [7:0] loc = {err_req[0], err_req[1], halt_req, host, timer_req};
  wire [10:0] mir = {gfx_req[62], gfx_req[57:53], gfx_req[19:18], gfx_req[10:9], gfx_req[7]};
  wire [1:0] sum = {|(gfx_req[63:32] & ~`IRQA_MIRROR_HI), |(gfx_req[31:0] & ~`IRQA_MIRROR_LO)};
  wire [2:0] msg = route_q ? {door_req[1:0], mbox_req[0]} : {door_req[3:2], mbox_req[1]};
  wire [31:0] glo = gfx_req[31:0];
  wire [31:0] ghi = gfx_req[63:32];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Two sync flops plus an output flop: three steady edges settle a request
  sequence steady;
    ($stable(req))[*3];
  endsequence
  sequence rd_at(a);
    steady ##0 (psel && !penable && !pwrite && paddr == a);
  endsequence
  chk_idle_normal: assert property ((!(|req))[*3] |=> !normal_irq)
    else $error("normal line high without request");
  chk_idle_fast: assert property ((!(|req))[*3] |=> !fast_irq)
    else $error("fast line high without request");
  chk_msg_route: assert property (steady |=> gfx_msg_irq == $past(msg))
    else $error("message lines wrong");
  chk_basic_local: assert property (rd_at(`IRQA_OFF_BASIC) |=> prdata[7:0] == $past(loc))
    else $error("basic local bits wrong");
  chk_basic_mirror: assert property (rd_at(`IRQA_OFF_BASIC) |=> prdata[31:10] == {11'h0, $past(mir)})
    else $error("basic mirror bits wrong");
  chk_basic_summary: assert property (rd_at(`IRQA_OFF_BASIC) |=> prdata[9:8] == $past(sum))
    else $error("summary bits wrong");
  chk_gfx_low: assert property (rd_at(`IRQA_OFF_PEND_LO) |=> prdata == $past(glo))
    else $error("low pending wrong");
  chk_gfx_high: assert property (rd_at(`IRQA_OFF_PEND_HI) |=> prdata == $past(ghi))
    else $error("high pending wrong");
endmodule // irqa_chk
bind irqa_top irqa_chk #(.NGFX(NGFX)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .gfx_req(gfx_req),
  .timer_req(timer_req), .mbox_req(mbox_req), .door_req(door_req), .halt_req(halt_req),
  .err_req(err_req), .normal_irq(normal_irq), .fast_irq(fast_irq), .gfx_msg_irq(gfx_msg_irq));
`default_nettype wire

//--- test/irqa_host.sv
/* Host core model: polls, and flags a normal and fast fire together.
   Assumes levels synchronous to pclk. */
`timescale 1ns/10ps
`default_nettype none
module irqa_host (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Lines
  input wire logic normal_irq,
  input wire logic fast_irq,
  // Observation
  output logic both_seen
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      both_seen <= 1'b0;
    else if (normal_irq && fast_irq)
      both_seen <= 1'b1;
  end
endmodule // irqa_host
`default_nettype wire

//--- test/tb_irq_pending_aggregator.sv
/* Self-checking bench for irqa_top with a host model.
   Assumes zero-wait APB and three-edge request latency. */
`timescale 1ns/10ps
`default_nettype none
`include "irqa_regs.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_irq_pending_aggregator;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] gfx_req = 64'h0;
  logic [10:0] loc_req = 11'h0;
  logic [31:0] prdata, q;
  logic [31:0] seed = 32'h47;
  logic [2:0] gfx_msg_irq;
  logic pready, pslverr, normal_irq, fast_irq, status_irq, both_seen, slv;
  int fails = 0;
  int compares = 0;
  always #10 pclk = ~pclk;
  irqa_top #(.NGFX(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gfx_req(gfx_req), .timer_req(loc_req[10]), .mbox_req(loc_req[9:8]),
    .door_req(loc_req[7:4]), .halt_req(loc_req[3:2]), .err_req(loc_req[1:0]),
    .normal_irq(normal_irq), .fast_irq(fast_irq), .gfx_msg_irq(gfx_msg_irq), .status_irq(status_irq));
  irqa_host host (.pclk(pclk), .presetn(presetn), .normal_irq(normal_irq), .fast_irq(fast_irq),
    .both_seen(both_seen));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Host-routed local bits in basic register order
  function automatic logic [7:0] hl(logic [10:0] r);
    return {r[0], r[1], r[3], r[2], r[5], r[4], r[8], r[10]};
  endfunction
  function automatic logic [31:0] exp_basic(logic [63:0] g, logic [10:0] r);
    return {11'h0, g[62], g[57:53], g[19:18], g[10:9], g[7], |(g[63:32] & ~32'h43e00000),
      |(g[31:0] & ~32'h000c0680), hl(r)};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Enable or disable triple: low, high, basic
  task automatic all3(input logic [11:0] a);
    apb(1'b1, a, 32'hffffffff);
    apb(1'b1, a + 12'h4, 32'hffffffff);
    apb(1'b1, a + 12'h8, 32'h000000ff);
  endtask
  task automatic drive(input logic [63:0] g, input logic [10:0] r);
    gfx_req <= g;
    loc_req <= r;
    repeat (4) @(posedge pclk);
  endtask
  task results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    results();
  end
  initial begin
    logic [63:0] g;
    logic [10:0] r;
    logic [6:0] s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IRQA_OFF_EN_LO, 32'h0);
    `CHK("enable reset", 32'h0, q)
    `CHK("no error", 1'b0, slv)
    apb(1'b0, `IRQA_OFF_FAST, 32'h0);
    `CHK("fast reset", 32'h0, q)
    all3(`IRQA_OFF_EN_LO);
    for (int i = 0; i < 24; i++) begin
      g = {rnd(), rnd()};
      r = 11'(rnd());
      if (i == 0) g = 64'hffffffffffffffff;
      if (i == 1) g = 64'h43e00000000c0680;
      if (i == 2) {g, r} = 75'h0;
      drive(g, r);
      apb(1'b0, `IRQA_OFF_BASIC, 32'h0);
      `CHK("basic", exp_basic(g, r), q)
      apb(1'b0, `IRQA_OFF_PEND_LO, 32'h0);
      `CHK("gfx low", g[31:0], q)
      apb(1'b0, `IRQA_OFF_PEND_HI, 32'h0);
      `CHK("gfx high", g[63:32], q)
      `CHK("normal", |{g, hl(r)}, normal_irq)
      `CHK("msg", {r[7:6], r[9]}, gfx_msg_irq)
    end
    drive(64'hffffffffffffffff, 11'h7ff);
    all3(`IRQA_OFF_DIS_LO);
    // The line drops one edge after the last disable lands
    @(posedge pclk);
    `CHK("normal disabled", 1'b0, normal_irq)
    apb(1'b0, `IRQA_OFF_EN_HI, 32'h0);
    `CHK("enable cleared", 32'h0, q)
    all3(`IRQA_OFF_EN_LO);
    // Source 64 is the timer; pass 4 leaves the fast enable off
    for (int j = 0; j < 6; j++) begin
      s = (j == 5) ? 7'h40 : 7'(rnd() % 64);
      drive(64'h0, 11'h0);
      apb(1'b1, `IRQA_OFF_FAST, {24'h0, j != 4, s});
      drive(s[6] ? 64'h0 : 64'h1 << s, s[6] ? 11'h400 : 11'h0);
      `CHK("fast", j != 4, fast_irq)
      `CHK("normal beside fast", j == 4, normal_irq)
      drive(64'h0, 11'h0);
      `CHK("fast released", 1'b0, fast_irq)
    end
    // Swapped routing hands doorbells 0/1 and mailbox 0 to the graphics side
    apb(1'b1, `IRQA_OFF_ROUTE, 32'h1);
    drive(64'h0, 11'h130);
    apb(1'b0, `IRQA_OFF_BASIC, 32'h0);
    `CHK("basic swapped", 32'h0, q)
    `CHK("msg swapped", 3'h7, gfx_msg_irq)
    drive(64'h0, 11'h0);
    apb(1'b1, `IRQA_OFF_ROUTE, 32'h0);
    // Normal and fast lines have both risen by now, no bad access yet
    apb(1'b0, `IRQA_OFF_EV_STAT, 32'h0);
    `CHK("event status", 32'h3, q)
    apb(1'b1, `IRQA_OFF_EV_MASK, 32'h0);
    apb(1'b1, `IRQA_OFF_EV_STAT, 32'h7);
    apb(1'b0, 12'h300, 32'h0);
    `CHK("bad address", 1'b1, slv)
    `CHK("event masked", 1'b0, status_irq)
    apb(1'b1, `IRQA_OFF_EV_MASK, 32'h4);
    @(posedge pclk);
    `CHK("event raised", 1'b1, status_irq)
    apb(1'b1, `IRQA_OFF_EV_STAT, 32'h4);
    `CHK("event cleared", 1'b0, status_irq)
    `CHK("double fire", 1'b0, both_seen)
    results();
  end
endmodule // tb_irq_pending_aggregator
`default_nettype wire
